// file: core/cif_contact_inputs.v
// contact input function mapping for two contact closure inputs
`include "cif_regs.vh"
// a pin change reaches contact_level once it has held for the
// whole debounce window, and the function outputs one cycle later;
// level-defined functions follow the filtered contact, the rest fire
// once per filtered closure or opening
// a selector write takes effect at the next clock edge
// two inputs share one decoder; their results are or-ed
// What this block does
// R1: act on closing edge unless level-defined
// R2: per-input selector, resets to unused
// R3: closure acknowledges all active alarms
// R4: closed picks setpoint two, open one
// R5: closed contact locks front panel keys
// R6: closure resets a running timer
// R7: closure starts the timer running
// R8: run while closed, reset on opening
// R9: closure freezes timer at elapsed value
// R10: held closure in auto selects manual
// R11: close then open in manual returns auto
// R12: idle mode forces all demand zero
// R13: second input offers identical functions
// R14: synchronise and debounce each input
module cif_contact_inputs
(
  // clock and synchronous reset
  input  wire       clk,
  input  wire       rst_b,
  // raw contact pins, asynchronous to clk
  input  wire       contact_one_in,
  input  wire       contact_two_in,
  // configuration from the set-up logic
  input  wire       input_two_fitted,
  input  wire       sel_wr,
  input  wire [3:0] input_one_function_select_in,
  input  wire [3:0] input_two_function_select_in,
  // controller state
  input  wire       alarms_active,
  input  wire       timer_running,
  input  wire       ctrl_is_manual,
  // selector readback
  output wire [3:0] input_one_function_select,
  output wire [3:0] input_two_function_select,
  // alarm acknowledge pulse
  output wire       alarm_ack,
  // level-defined outputs
  output wire       setpoint_two_sel,
  output wire       setpoint_choice_active,
  output wire       panel_locked,
  // timer and mode pulses
  output wire       timer_clear,
  output wire       timer_go,
  output wire       timer_pause,
  output wire       manual_req,
  output wire       auto_req,
  // zero demand
  output wire       demand_zero,
  // filtered contact levels
  output wire [1:0] contact_level
);
  // selector store and input front end
  reg  [3:0] fn_reg [0:1];      // function selectors per input
  wire [1:0] pin_sync;          // synchronised pins
  wire [1:0] lvl;               // debounced levels
  wire [1:0] rise;              // closing edges
  wire [1:0] fall;              // opening edges
  wire [1:0] pin_raw;           // pins in index order
  reg  [1:0] man_armed_reg;     // closure seen while in manual
  // registered decode results
  reg        alarm_ack_reg;     // acknowledge pulse
  reg        sp_two_reg;        // setpoint two selected
  reg        sp_act_reg;        // setpoint choice owned by an input
  reg        lock_reg;          // panel lock
  reg        clr_reg;           // timer clear pulse
  reg        go_reg;            // timer go pulse
  reg        pause_reg;         // timer pause pulse
  reg        man_reg;           // manual request pulse
  reg        auto_reg;          // auto request pulse
  reg        zero_reg;          // demand forced to zero

  // next values, built fresh each cycle by the decoder
  reg        ack_next;          // acknowledge wanted
  reg        sp_two_next;       // setpoint two wanted
  reg        sp_act_next;       // some input owns setpoint choice
  reg        lock_next;         // lock wanted
  reg        clr_next;          // clear wanted
  reg        go_next;           // go wanted
  reg        pause_next;        // pause wanted
  reg        man_next;          // manual wanted
  reg        auto_next;         // auto wanted
  reg        zero_next;         // zero demand wanted
  reg  [1:0] man_armed_next;    // arming for the next cycle

  // decoder scratch
  reg  [3:0] fn;                // selector of the input in hand
  integer    i;                 // input index

  // gather both pins so the loop below can index them
  assign pin_raw = {contact_two_in, contact_one_in};

  // one synchroniser and filter per input
  // pins are asynchronous; nothing reads them before two flops
  // a throw that chatters still yields one filtered event
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_in
      cif_sync u_sync
      (
        .clk      (clk),
        .rst_b    (rst_b),
        .pin_in   (pin_raw[g]),
        .pin_sync (pin_sync[g])
      ); // R14
      cif_debounce u_deb
      (
        .clk    (clk),
        .rst_b  (rst_b),
        .raw_in (pin_sync[g]),
        .level  (lvl[g]),
        .rise   (rise[g]),
        .fall   (fall[g])
      ); // R14
    end
  endgenerate

  // selector storage; unfitted second input stays unused
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      // both inputs unused until configured
      fn_reg[0] <= `CIF_FN_RESET; // R2
      fn_reg[1] <= `CIF_FN_RESET; // R2
    end
    else if (sel_wr)
    begin
      // a write loads both selectors together
      fn_reg[0] <= input_one_function_select_in;
      // an input that is not fitted never carries a function
      fn_reg[1] <= input_two_fitted ? input_two_function_select_in : `CIF_FN_RESET;
    end
  end

  // map both inputs through one shared decoder; results are or-ed
  // levels feed the level-defined functions, edges the rest
  // or-ing lets both inputs share a function without a conflict
  always @*
  begin
    // every output defaults low on every path
    ack_next       = 1'b0;
    sp_two_next    = 1'b0;
    sp_act_next    = 1'b0;
    lock_next      = 1'b0;
    clr_next       = 1'b0;
    go_next        = 1'b0;
    pause_next     = 1'b0;
    man_next       = 1'b0;
    auto_next      = 1'b0;
    zero_next      = 1'b0;
    // arming carries over unless a branch below changes it
    man_armed_next = man_armed_reg;
    // scratch value set first so no latch is inferred
    fn             = `CIF_FN_UNUSED;
    // the same decoder serves both inputs
    for (i = 0; i < 2; i = i + 1)
    begin
      fn = fn_reg[i]; // R13
      // codes ten to fifteen fall to the default and act as unused
      case (fn)
        `CIF_FN_ALARM_ACK:
        begin
          // edge only, every active alarm at once
          ack_next = ack_next | (rise[i] & alarms_active); // R1 R3
        end
        `CIF_FN_SP_CHOICE:
        begin
          // closed picks setpoint two, open setpoint one
          sp_act_next = 1'b1;
          sp_two_next = sp_two_next | lvl[i]; // R4
        end
        `CIF_FN_KEYLOCK:
        begin
          // level-defined: the lock lasts as long as the closure
          lock_next = lock_next | lvl[i]; // R5
        end
        `CIF_FN_TIMER_CLEAR:
        begin
          // only a running sequence is sent back to reset
          clr_next = clr_next | (rise[i] & timer_running); // R1 R6
        end
        `CIF_FN_TIMER_GO:
        begin
          // one start request per filtered closure
          go_next = go_next | rise[i]; // R1 R7
        end
        `CIF_FN_TIMER_GOCLR:
        begin
          // closure runs the timer, opening clears it whatever its state
          go_next  = go_next | rise[i];  // R8
          clr_next = clr_next | fall[i]; // R8
        end
        `CIF_FN_TIMER_PAUSE:
        begin
          // the timer itself keeps the elapsed value
          pause_next = pause_next | rise[i]; // R1 R9
        end
        `CIF_FN_MANUAL:
        begin
          // in auto a closure held past debounce selects manual
          if (!ctrl_is_manual && rise[i])
          begin
            // nothing armed: the opening of this throw must not return to auto
            man_next          = 1'b1; // R10
            man_armed_next[i] = 1'b0;
          end
          else if (ctrl_is_manual && rise[i])
          begin
            // in manual a closure only arms the return
            man_armed_next[i] = 1'b1; // R11
          end
          else if (ctrl_is_manual && fall[i] && man_armed_reg[i])
          begin
            // the opening completes the return to auto
            auto_next         = 1'b1; // R11
            man_armed_next[i] = 1'b0;
          end
          else if (!ctrl_is_manual)
          begin
            // back in auto by other means: drop a stale arm
            man_armed_next[i] = 1'b0;
          end
        end
        `CIF_FN_IDLE:
        begin
          // zero demand for as long as the contact stays closed
          zero_next = zero_next | lvl[i]; // R12
        end
        default:
        begin
          // unused: input changes have no effect
          man_armed_next[i] = 1'b0; // R2
        end
      endcase
      // arming belongs to the manual function alone
      if (fn != `CIF_FN_MANUAL)
      begin
        man_armed_next[i] = 1'b0;
      end
    end
  end

  // register every output so data outputs come from flip-flops
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      // all outputs low in reset, nothing armed
      alarm_ack_reg <= 1'b0;
      sp_two_reg    <= 1'b0;
      sp_act_reg    <= 1'b0;
      lock_reg      <= 1'b0;
      clr_reg       <= 1'b0;
      go_reg        <= 1'b0;
      pause_reg     <= 1'b0;
      man_reg       <= 1'b0;
      auto_reg      <= 1'b0;
      zero_reg      <= 1'b0;
      man_armed_reg <= 2'h0;
    end
    else
    begin
      // pulses last exactly one cycle; levels track the decode
      alarm_ack_reg <= ack_next;
      sp_two_reg    <= sp_two_next;
      sp_act_reg    <= sp_act_next;
      lock_reg      <= lock_next;
      clr_reg       <= clr_next;
      go_reg        <= go_next;
      pause_reg     <= pause_next;
      man_reg       <= man_next;
      auto_reg      <= auto_next;
      zero_reg      <= zero_next;
      // arming is internal state, never an output
      man_armed_reg <= man_armed_next;
    end
  end

  // readback and function outputs come straight from flip-flops
  // contact_level is the filter's own register
  assign input_one_function_select = fn_reg[0];
  assign input_two_function_select = fn_reg[1];
  assign alarm_ack                 = alarm_ack_reg;
  assign setpoint_two_sel          = sp_two_reg;
  assign setpoint_choice_active    = sp_act_reg;
  assign panel_locked              = lock_reg;
  assign timer_clear               = clr_reg;
  assign timer_go                  = go_reg;
  assign timer_pause               = pause_reg;
  assign manual_req                = man_reg;
  assign auto_req                  = auto_reg;
  assign demand_zero               = zero_reg;
  assign contact_level             = lvl;
endmodule

// file: core/cif_debounce.v
// debounce filter with closing and opening edge pulses
`include "cif_regs.vh"
module cif_debounce
(
  input  wire clk,
  input  wire rst_b,
  input  wire raw_in,
  output wire level,
  output wire rise,
  output wire fall
);
  reg                        level_reg; // accepted contact level
  reg [`CIF_DEBOUNCE_W-1:0]  cnt_reg;   // stability counter
  reg                        rise_reg;  // closure pulse
  reg                        fall_reg;  // opening pulse

  // accept a new level only after it has held for the whole window
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      level_reg <= 1'b0;
      cnt_reg   <= {`CIF_DEBOUNCE_W{1'b0}};
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
    end
    else
    begin
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      if (raw_in == level_reg)
      begin
        cnt_reg <= {`CIF_DEBOUNCE_W{1'b0}};
      end
      else if (cnt_reg == `CIF_DEBOUNCE_LAST)
      begin
        // bounce inside the window restarts it, so one event per change
        level_reg <= raw_in;
        cnt_reg   <= {`CIF_DEBOUNCE_W{1'b0}};
        rise_reg  <= raw_in;
        fall_reg  <= ~raw_in;
      end
      else
      begin
        cnt_reg <= cnt_reg + {{(`CIF_DEBOUNCE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign level = level_reg;
  assign rise  = rise_reg;
  assign fall  = fall_reg;
endmodule

// file: core/cif_regs.vh
// constants for the contact input function logic
`ifndef CIF_REGS_VH
`define CIF_REGS_VH
// function selector encodings (4 bits)
`define CIF_FN_WIDTH        4
`define CIF_FN_UNUSED       4'h0
`define CIF_FN_ALARM_ACK    4'h1
`define CIF_FN_SP_CHOICE    4'h2
`define CIF_FN_KEYLOCK      4'h3
`define CIF_FN_TIMER_CLEAR  4'h4
`define CIF_FN_TIMER_GO     4'h5
`define CIF_FN_TIMER_GOCLR  4'h6
`define CIF_FN_TIMER_PAUSE  4'h7
`define CIF_FN_MANUAL       4'h8
`define CIF_FN_IDLE         4'h9
// selector reset value
`define CIF_FN_RESET        4'h0
// debounce time in microseconds and cycles at 250 MHz
`define CIF_CLK_MHZ         250
`define CIF_DEBOUNCE_US     10
`define CIF_DEBOUNCE_CYC    (`CIF_DEBOUNCE_US * `CIF_CLK_MHZ)
`define CIF_DEBOUNCE_W      12
// last count of the window, debounce cycles minus one; keep in step with the above
`define CIF_DEBOUNCE_LAST   12'h9C3
`endif

// file: core/cif_sync.v
// two flip-flop synchroniser for one contact pin
module cif_sync
(
  input  wire clk,
  input  wire rst_b,
  input  wire pin_in,
  output wire pin_sync
);
  reg meta_reg; // first stage, read only by second
  reg sync_reg; // second stage

  // double register the asynchronous pin
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;
endmodule

// file: sim/cif_contact_inputs_chk.sv
// assertion checker bound to the contact input function logic
module cif_contact_inputs_chk
(
  input wire       clk,
  input wire       rst_b,
  input wire       sel_wr,
  input wire       input_two_fitted,
  input wire       alarms_active,
  input wire       timer_running,
  input wire       ctrl_is_manual,
  input wire [3:0] input_one_function_select_in,
  input wire [3:0] input_one_function_select,
  input wire [3:0] input_two_function_select,
  input wire       alarm_ack,
  input wire       timer_clear,
  input wire       timer_go,
  input wire       timer_pause,
  input wire       manual_req,
  input wire       auto_req,
  input wire       demand_zero,
  input wire [1:0] contact_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // both selectors side by side, passed in so properties see sampled values
  wire [7:0] sel_pair = {input_one_function_select, input_two_function_select};
  // true when either input carries code c
  function automatic bit uses(input [7:0] p, input [3:0] c);
    return p[7:4] == c || p[3:0] == c;
  endfunction
  a_sel_readback: assert property (
    sel_wr |=> input_one_function_select == $past(input_one_function_select_in))
    else $error("selector one readback wrong");
  a_two_unfitted: assert property (
    sel_wr && !input_two_fitted |=> input_two_function_select == 4'h0)
    else $error("unfitted selector not unused");
  a_ack_cause: assert property (
    alarm_ack |-> $past(alarms_active) && uses($past(sel_pair), 4'h1))
    else $error("stray acknowledge");
  a_go_cause: assert property (
    timer_go |-> uses($past(sel_pair), 4'h5) || uses($past(sel_pair), 4'h6))
    else $error("stray timer go");
  a_clear_cause: assert property (
    timer_clear |-> uses($past(sel_pair), 4'h4) && $past(timer_running)
      || uses($past(sel_pair), 4'h6))
    else $error("stray timer clear");
  a_pause_cause: assert property (
    timer_pause |-> uses($past(sel_pair), 4'h7))
    else $error("stray timer pause");
  a_manual_auto: assert property (
    manual_req |-> !$past(ctrl_is_manual) && uses($past(sel_pair), 4'h8))
    else $error("manual request out of auto");
  a_auto_manual: assert property (
    auto_req |-> $past(ctrl_is_manual) && uses($past(sel_pair), 4'h8))
    else $error("auto request out of manual");
  a_idle_follow: assert property (
    $rose(contact_level[0]) && input_one_function_select == 4'h9 |-> ##[1:2] demand_zero)
    else $error("idle closure left demand");
  c_go: cover property (timer_go);
  c_back_auto: cover property (auto_req);
  c_idle: cover property (demand_zero);
endmodule
bind cif_contact_inputs cif_contact_inputs_chk chk_u (.*);

// file: sim/cif_contact_inputs_tb.sv
// self-checking bench for the contact input function logic
`include "cif_regs.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module cif_contact_inputs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg        clk = 1'b0, rst_b = 1'b0, sel_wr = 1'b0, fitted = 1'b1;
  reg        alarms = 1'b0, running = 1'b0, manual = 1'b0;
  reg  [1:0] want = 2'h0;              // commanded contact positions
  reg  [3:0] s1_in = 4'h0, s2_in = 4'h0, code;
  reg  [7:0] lfsr = 8'h14;             // random source, seeded at 20
  wire [1:0] pin, lv;
  wire [3:0] s1, s2;
  wire       aa, sp2, spa, lk, tc, tg, tp, mr, ar, dz;
  wire [5:0] pulses = {aa, tc, tg, tp, mr, ar};
  wire [3:0] levels = {sp2, spa, lk, dz};
  integer    n_fail = 0, samples_checked = 0, cyc = 0, i;
  cif_contact_model mdl_u (.clk(clk), .want(want), .pin(pin));
  cif_contact_inputs dut_u (.clk(clk), .rst_b(rst_b), .contact_one_in(pin[0]),
    .contact_two_in(pin[1]), .input_two_fitted(fitted), .sel_wr(sel_wr),
    .input_one_function_select_in(s1_in), .input_two_function_select_in(s2_in),
    .alarms_active(alarms), .timer_running(running), .ctrl_is_manual(manual),
    .input_one_function_select(s1), .input_two_function_select(s2), .alarm_ack(aa),
    .setpoint_two_sel(sp2), .setpoint_choice_active(spa), .panel_locked(lk),
    .timer_clear(tc), .timer_go(tg), .timer_pause(tp), .manual_req(mr),
    .auto_req(ar), .demand_zero(dz), .contact_level(lv));
  always #2 clk = ~clk;
  // hang guard: 36 filtered throws need about 92k cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 99000)
    begin
      n_fail++;
      conclude;
    end
  end
  function [7:0] step(input [7:0] v);
    step = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // pulses expected from one filtered throw: close=1 closing, 0 opening
  function [5:0] exp_p(input [3:0] c, input cl, input al, input run, input man);
    exp_p = {c == 1 && cl && al, (c == 4 && cl && run) || (c == 6 && !cl),
      (c == 5 || c == 6) && cl, c == 7 && cl, c == 8 && cl && !man, c == 8 && !cl && man};
  endfunction
  task wsel(input [3:0] a, input [3:0] b);
    begin
      s1_in = a;
      s2_in = b;
      sel_wr = 1'b1;
      @(negedge clk);
      sel_wr = 1'b0;
      @(negedge clk);
      `CHK("sel_one", a, s1)
      `CHK("sel_two", fitted ? b : 4'h0, s2)
    end
  endtask
  // throw contact w to v, count pulses over the filter window plus 40 cycles
  task ev(input integer w, input v);
    reg [5:0] seen;
    integer   n, k;
    begin
      seen = 6'h00;
      n = 0;
      want[w] = v;
      for (k = 0; k < `CIF_DEBOUNCE_CYC + 40; k++)
      begin
        @(negedge clk);
        seen |= pulses;
        n += $countones(pulses);
      end
      `CHK("pulses", exp_p(code, v, alarms, running, manual), seen)
      `CHK("pulse_count", $countones(exp_p(code, v, alarms, running, manual)), n)
      `CHK("levels", {code == 2 && v, code == 2, code == 3 && v, code == 9 && v}, levels)
      `CHK("contact_level", v, lv[w])
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    `CHK("reset_out", 18'h00000, {s1, s2, pulses, levels})
    for (i = 0; i < 6; i++)
    begin
      lfsr = step(lfsr);
      fitted = lfsr[0];
      wsel(lfsr[7:4], lfsr[4:1]);
    end
    fitted = 1'b1;
    // every function on input one, then on input two
    for (i = 0; i < 18; i++)
    begin
      lfsr = step(lfsr);
      {alarms, running, manual} = lfsr[2:0];
      code = i % 9 + 1;
      if (i < 9)
        wsel(code, 4'h0);
      else
        wsel(4'h0, code);
      ev(i / 9, 1'b1);
      ev(i / 9, 1'b0);
    end
    conclude;
  end
endmodule

// file: sim/cif_contact_model.sv
// bouncing contact pair standing in for the external switches
module cif_contact_model
(
  input  wire       clk,
  input  wire [1:0] want,
  output reg  [1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [4:0] bnc_reg [0:1]; // chatter cycles left per contact
  integer   k;             // contact index
  initial
  begin
    pin = 2'h0;
    bnc_reg[0] = 5'h00;
    bnc_reg[1] = 5'h00;
  end
  // chatter 20 cycles per throw, far below the filter time, then settle
  always @(posedge clk)
    for (k = 0; k < 2; k = k + 1)
      if (bnc_reg[k] != 5'h00)
      begin
        bnc_reg[k] <= bnc_reg[k] - 5'h01;
        pin[k]     <= (bnc_reg[k] == 5'h01) ? want[k] : bnc_reg[k][2];
      end
      else if (pin[k] != want[k])
        bnc_reg[k] <= 5'h14;
endmodule
